// ---- core/vram_strobe_pkg.sv ----
// constants, field layout and state types for the vram strobe and refresh block
// assumes a 40 MHz pclk and an APB master with 32-bit data
package vram_strobe_pkg;

   // -----------------------------------------------------------------
   // register map
   // -----------------------------------------------------------------
   localparam int unsigned APB_AW = 12;
   localparam logic [11:0] CONFIG_OFFSET = 12'h000;
   localparam logic [11:0] STATUS_OFFSET = 12'h004;

   localparam int unsigned CONFIG_W = 10;
   localparam int unsigned PRESCALE_LSB = 0;
   localparam int unsigned FINE_BIT = 3;
   localparam int unsigned CODE_LSB = 4;
   localparam int unsigned PIPE_BIT = 8;
   localparam int unsigned STAGGER_BIT = 9;
   localparam logic [CONFIG_W-1:0] CONFIG_RESET = 10'h030;

   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_PEND_BIT = 3;
   localparam int unsigned STAT_COUNT_LSB = 16;

   // -----------------------------------------------------------------
   // vram geometry
   // -----------------------------------------------------------------
   localparam int unsigned VRAM_AW = 11;
   localparam int unsigned STROBES = 4;

   // -----------------------------------------------------------------
   // refresh clock division
   // -----------------------------------------------------------------
   localparam logic [3:0] PRESCALE_BASE = 4'hA;
   localparam logic [4:0] FINE_DIV_COARSE = 5'h1E;
   localparam logic [4:0] FINE_DIV_FINE = 5'h1A;
   localparam int unsigned REFRESH_PERIOD_COARSE_US = 15;
   localparam int unsigned REFRESH_PERIOD_FINE_US = 13;

   // -----------------------------------------------------------------
   // access and refresh timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned COL_HOLD_NS = 15;
   localparam int unsigned COL_HOLD_RAW = (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned COL_HOLD_CYCLES = (COL_HOLD_RAW < 1) ? 1 : COL_HOLD_RAW;
   localparam logic [2:0] COL_HOLD_CNT = 3'(COL_HOLD_CYCLES);
   localparam logic [2:0] REF_LOW_CNT = 3'h2;
   localparam logic [2:0] PRECHARGE_CNT = 3'h1;

   typedef enum logic [2:0] {
      CFG_ALL_SCRUB = 3'h0,
      CFG_PAIR_SCRUB = 3'h1,
      CFG_SINGLE_SCRUB = 3'h2,
      CFG_ALL = 3'h3,
      CFG_ROW_PAIR = 3'h4,
      CFG_PAIR = 3'h5,
      CFG_ROW_SINGLE = 3'h6,
      CFG_SINGLE = 3'h7
   } strobe_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ROW = 3'h1,
      ST_COL = 3'h3,
      ST_PRE = 3'h2,
      ST_REF = 3'h6
   } seq_state_t;

endpackage

// ---- core/strobe_select.sv ----
// row and column strobe selection from the configuration code and bank inputs
// assumes bank inputs are held stable for the access
`timescale 1ns/1ps
`default_nettype none
module strobe_select
   import vram_strobe_pkg::*;
(
   input wire logic [2:0] strobe_config_code,
   input wire logic bank_select_high,
   input wire logic bank_select_low,
   input wire logic [STROBES-1:0] column_enable_in,
   output logic [STROBES-1:0] row_sel,
   output logic [STROBES-1:0] col_sel,
   output logic pair_mode
);

   function automatic logic [STROBES-1:0] one_hot(input logic [1:0] idx);
      one_hot = 4'h1 << idx;
   endfunction

   function automatic logic [STROBES-1:0] pair_hot(input logic high);
      pair_hot = high ? 4'hC : 4'h3;
   endfunction

   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   // lower bank select unused by the pair decode
   wire logic [STROBES-1:0] pair_w = pair_hot(bank_select_high);
   wire logic [STROBES-1:0] single_w = one_hot({bank_select_high, bank_select_low});
   logic [STROBES-1:0] row_w;
   logic [STROBES-1:0] col_w;

   always_comb begin
      case (strobe_cfg_t'(strobe_config_code))
         CFG_ALL_SCRUB, CFG_ALL: begin
            row_w = 4'hF;
            col_w = 4'hF;
         end
         CFG_ROW_PAIR: begin
            row_w = pair_w;
            col_w = 4'hF;
         end
         CFG_PAIR_SCRUB, CFG_PAIR: begin
            row_w = pair_w;
            col_w = pair_w;
         end
         CFG_ROW_SINGLE: begin
            row_w = single_w;
            col_w = 4'hF;
         end
         CFG_SINGLE_SCRUB, CFG_SINGLE: begin
            row_w = single_w;
            col_w = single_w;
         end
         default: begin
            row_w = 4'hF;
            col_w = 4'hF;
         end
      endcase
   end

   assign row_sel = row_w;
   // column enable gating
   assign col_sel = col_w & column_enable_in;
   assign pair_mode = (strobe_config_code == CFG_PAIR_SCRUB) || (strobe_config_code == CFG_ROW_PAIR) ||
                      (strobe_config_code == CFG_PAIR);

endmodule
`default_nettype wire

// ---- core/refresh_timer.sv ----
// refresh request timer: prescaler then fine divisor on delay line edges
// assumes dl_rise is a one-cycle pulse already synchronised to pclk
`timescale 1ns/1ps
`default_nettype none
module refresh_timer
   import vram_strobe_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic dl_rise,
   input wire logic [2:0] refresh_prescale_code,
   input wire logic refresh_fine_divisor_bit,
   output logic refresh_tick
);

   logic [3:0] pre_cnt_q;
   logic [4:0] fine_cnt_q;
   logic tick_q;

   // -----------------------------------------------------------------
   // dividers
   // -----------------------------------------------------------------
   // divisor ten minus code
   wire logic [3:0] pre_last = PRESCALE_BASE - {1'b0, refresh_prescale_code} - 4'h1;
   wire logic pre_tick = dl_rise && (pre_cnt_q >= pre_last);
   wire logic [4:0] fine_last = (refresh_fine_divisor_bit ? FINE_DIV_FINE : FINE_DIV_COARSE) - 5'h01;
   wire logic fine_wrap = fine_cnt_q >= fine_last;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt_q <= 4'h0;
      end else if (pre_tick) begin
         pre_cnt_q <= 4'h0;
      end else if (dl_rise) begin
         pre_cnt_q <= pre_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fine_cnt_q <= 5'h00;
      end else if (pre_tick) begin
         fine_cnt_q <= fine_wrap ? 5'h00 : fine_cnt_q + 5'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= pre_tick && fine_wrap;
      end
   end

   assign refresh_tick = tick_q;

endmodule
`default_nettype wire

// ---- core/vram_strobe_config_decode.sv ----
// vram strobe sequencer with configuration decode, refresh timing and apb registers
// assumes host access signals on pclk and a free running delay line clock pin
`timescale 1ns/1ps
`default_nettype none
module vram_strobe_config_decode
   import vram_strobe_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic delay_line_clock,
   input wire logic access_req,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [STROBES-1:0] column_enable_in,
   input wire logic [VRAM_AW-1:0] row_addr,
   input wire logic [VRAM_AW-1:0] col_addr,
   output logic [STROBES-1:0] row_strobe_n,
   output logic [STROBES-1:0] col_strobe_n,
   output logic [VRAM_AW-1:0] vram_addr,
   output logic access_busy,
   output logic refresh_busy
);

   // -----------------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------------
   logic [CONFIG_W-1:0] config_q;
   logic [31:0] rdata_q;
   logic [15:0] refresh_count_q;
   logic refresh_pend_q;
   seq_state_t state_q;

   wire logic hit_config = (paddr == CONFIG_OFFSET);
   wire logic hit_status = (paddr == STATUS_OFFSET);
   wire logic addr_hit = hit_config || hit_status;
   wire logic setup_phase = psel && !penable;
   wire logic access_phase = psel && penable;
   wire logic config_write = access_phase && pwrite && hit_config;

   wire logic [31:0] status_word = ({29'h0, state_q} << STAT_STATE_LSB) |
                                   ({31'h0, refresh_pend_q} << STAT_PEND_BIT) |
                                   ({16'h0, refresh_count_q} << STAT_COUNT_LSB);
   wire logic [31:0] read_mux = hit_config ? {22'h0, config_q} : (hit_status ? status_word : 32'h0);

   // byte lane merge of a config write
   wire logic [CONFIG_W-1:0] config_merged = {pstrb[1] ? pwdata[9:8] : config_q[9:8],
                                              pstrb[0] ? pwdata[7:0] : config_q[7:0]};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_q <= CONFIG_RESET;
      end else if (config_write) begin
         config_q <= config_merged;
      end
   end

   // read data captured in setup, stable through access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0;
      end else if (setup_phase) begin
         rdata_q <= pwrite ? 32'h0 : read_mux;
      end
   end

   assign prdata = rdata_q;
   assign pready = 1'b1;
   assign pslverr = access_phase && !addr_hit;

   // -----------------------------------------------------------------
   // config fields
   // -----------------------------------------------------------------
   wire logic [2:0] refresh_prescale_code = config_q[PRESCALE_LSB +: 3];
   wire logic refresh_fine_divisor_bit = config_q[FINE_BIT];
   wire logic [2:0] strobe_config_code = config_q[CODE_LSB +: 3];
   wire logic address_pipeline_bit = config_q[PIPE_BIT];
   wire logic refresh_stagger_bit = config_q[STAGGER_BIT];

   // -----------------------------------------------------------------
   // delay line clock sync and refresh timer
   // -----------------------------------------------------------------
   logic dl_meta_q;
   logic dl_sync_q;
   logic dl_prev_q;
   logic refresh_tick;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dl_meta_q <= 1'b0;
         dl_sync_q <= 1'b0;
         dl_prev_q <= 1'b0;
      end else begin
         dl_meta_q <= delay_line_clock;
         dl_sync_q <= dl_meta_q;
         dl_prev_q <= dl_sync_q;
      end
   end

   wire logic dl_rise = dl_sync_q && !dl_prev_q;

   refresh_timer u_refresh_timer (
      .pclk(pclk),
      .presetn(presetn),
      .dl_rise(dl_rise),
      .refresh_prescale_code(refresh_prescale_code),
      .refresh_fine_divisor_bit(refresh_fine_divisor_bit),
      .refresh_tick(refresh_tick)
   );

   // -----------------------------------------------------------------
   // strobe decode
   // -----------------------------------------------------------------
   logic bank_high_q;
   logic bank_low_q;
   logic [STROBES-1:0] row_sel;
   logic [STROBES-1:0] col_sel;
   logic pair_mode;

   strobe_select u_strobe_select (
      .strobe_config_code(strobe_config_code),
      .bank_select_high(bank_high_q),
      .bank_select_low(bank_low_q),
      .column_enable_in(column_enable_in),
      .row_sel(row_sel),
      .col_sel(col_sel),
      .pair_mode(pair_mode)
   );

   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   seq_state_t state_d;
   logic [2:0] cnt_q;
   logic [2:0] cnt_d;

   wire logic [2:0] ref_skew = refresh_stagger_bit ? (pair_mode ? 3'h1 : 3'h3) : 3'h0;
   wire logic [2:0] ref_last = ref_skew + REF_LOW_CNT - 3'h1;
   wire logic start_refresh = (state_q == ST_IDLE) && refresh_pend_q;
   wire logic start_access = (state_q == ST_IDLE) && !refresh_pend_q && access_req;
   wire logic hold_met = cnt_q > COL_HOLD_CNT;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            cnt_d = 3'h0;
            if (start_refresh) begin
               state_d = ST_REF;
            end else if (start_access) begin
               state_d = ST_ROW;
            end
         end
         ST_ROW: begin
            state_d = ST_COL;
            cnt_d = 3'h0;
         end
         ST_COL: begin
            if (!hold_met) begin
               cnt_d = cnt_q + 3'h1;
            end
            if (!access_req) begin
               state_d = ST_PRE;
               cnt_d = 3'h0;
            end
         end
         ST_REF: begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q >= ref_last) begin
               state_d = ST_PRE;
               cnt_d = 3'h0;
            end
         end
         ST_PRE: begin
            cnt_d = cnt_q + 3'h1;
            if (cnt_q >= PRECHARGE_CNT - 3'h1) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = 3'h0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         cnt_q <= 3'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // bank inputs latched at access start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bank_high_q <= 1'b0;
         bank_low_q <= 1'b0;
      end else if (start_access) begin
         bank_high_q <= bank_select_high;
         bank_low_q <= bank_select_low;
      end
   end

   // pending refresh, a new tick wins over the clear
   wire logic refresh_pend_d = refresh_tick || (refresh_pend_q && !start_refresh);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         refresh_pend_q <= 1'b0;
         refresh_count_q <= 16'h0;
      end else begin
         refresh_pend_q <= refresh_pend_d;
         if (start_refresh) begin
            refresh_count_q <= refresh_count_q + 16'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // refresh row strobes
   // -----------------------------------------------------------------
   logic [STROBES-1:0] ref_rows;

   genvar gi;
   generate
      for (gi = 0; gi < STROBES; gi++) begin : g_ref
         wire logic [2:0] pair_start = 3'(gi / 2);
         wire logic [2:0] single_start = 3'(gi);
         wire logic [2:0] start = refresh_stagger_bit ? (pair_mode ? pair_start : single_start) : 3'h0;
         assign ref_rows[gi] = (state_q == ST_REF) && (cnt_q >= start) && (cnt_q < start + REF_LOW_CNT);
      end
   endgenerate

   // -----------------------------------------------------------------
   // output drive
   // -----------------------------------------------------------------
   wire logic in_access = (state_q == ST_ROW) || (state_q == ST_COL);
   wire logic cas_phase = (state_q == ST_COL) && (cnt_q != 3'h0);
   wire logic [STROBES-1:0] row_on = in_access ? row_sel : ref_rows;
   wire logic [STROBES-1:0] col_on = cas_phase ? col_sel : 4'h0;
   wire logic show_col = (state_q == ST_COL) && (address_pipeline_bit || !hold_met);
   wire logic [VRAM_AW-1:0] addr_d = show_col ? col_addr : row_addr;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         row_strobe_n <= 4'hF;
         col_strobe_n <= 4'hF;
         vram_addr <= 11'h000;
         access_busy <= 1'b0;
         refresh_busy <= 1'b0;
      end else begin
         row_strobe_n <= ~row_on;
         col_strobe_n <= ~col_on;
         vram_addr <= addr_d;
         access_busy <= in_access;
         refresh_busy <= (state_q == ST_REF);
      end
   end

endmodule
`default_nettype wire

// ---- tb/vram_expect.svh ----
// expected strobe masks per configuration code, bench side
// assumes bit i of a mask selects strobe i
function automatic logic [3:0] row_exp(input logic [2:0] c, input logic h, input logic l);
   case (c)
      3'h0, 3'h3: row_exp = 4'hF;
      3'h1, 3'h4, 3'h5: row_exp = h ? 4'hC : 4'h3;
      default: row_exp = 4'h1 << {h, l};
   endcase
endfunction
function automatic logic [3:0] col_exp(input logic [2:0] c, input logic h, input logic l);
   case (c)
      3'h0, 3'h3, 3'h4, 3'h6: col_exp = 4'hF;
      3'h1, 3'h5: col_exp = h ? 4'hC : 4'h3;
      default: col_exp = 4'h1 << {h, l};
   endcase
endfunction

// ---- tb/vram_strobe_sva.sv ----
// checker for the vram strobe block on its top ports
// assumes config is loaded only while no access is in flight
`timescale 1ns/1ps
`default_nettype none
module vram_strobe_sva
   import vram_strobe_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic bank_select_low,
   input wire logic bank_select_high,
   input wire logic [STROBES-1:0] column_enable_in,
   input wire logic [VRAM_AW-1:0] row_addr,
   input wire logic [VRAM_AW-1:0] col_addr,
   input wire logic [STROBES-1:0] row_strobe_n,
   input wire logic [STROBES-1:0] col_strobe_n,
   input wire logic [VRAM_AW-1:0] vram_addr,
   input wire logic access_busy
);
`include "vram_expect.svh"
   // ------------------------------------------------
   // config shadow, settled once no write for a while
   // ------------------------------------------------
   logic [CONFIG_W-1:0] cfg_q;
   logic [3:0] age_q;
   wire logic cfg_wr = psel && penable && pwrite && pready && paddr == CONFIG_OFFSET;
   wire logic [2:0] code = cfg_q[CODE_LSB +: 3];
   wire logic settled = age_q == 4'hF;
   wire logic [3:0] row_want = ~row_exp(code, bank_select_high, bank_select_low);
   wire logic [3:0] col_want = col_exp(code, bank_select_high, bank_select_low);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= CONFIG_RESET;
         age_q <= 4'h0;
      end else begin
         if (cfg_wr && pstrb[0])
            cfg_q[7:0] <= pwdata[7:0];
         if (cfg_wr && pstrb[1])
            cfg_q[9:8] <= pwdata[9:8];
         if (cfg_wr)
            age_q <= 4'h0;
         else if (!settled)
            age_q <= age_q + 4'h1;
      end
   end
   // ------------------------------------------------
   // properties
   // ------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_row_select: assert property (settled && access_busy |-> row_strobe_n == row_want)
      else $error("row strobes off selection");
   a_col_gated: assert property (settled && access_busy |->
      (~col_strobe_n & ~(col_want & $past(column_enable_in))) == 4'h0)
      else $error("column strobe outside selection");
   a_addr_return: assert property ((settled && access_busy && !cfg_q[PIPE_BIT])[*4] |->
      vram_addr == $past(row_addr))
      else $error("address not back to row");
   a_col_addr_held: assert property (settled && cfg_q[PIPE_BIT] && access_busy && $past(access_busy) |->
      vram_addr == $past(col_addr))
      else $error("column address dropped early");
   a_refresh_together: assert property (settled && !cfg_q[STAGGER_BIT] && !access_busy |->
      row_strobe_n inside {4'h0, 4'hF})
      else $error("refresh rows not together");
   a_stagger_step: assert property (settled && cfg_q[STAGGER_BIT] && !access_busy && $fell(row_strobe_n[2]) |->
      !$past(row_strobe_n[1]) && $past(row_strobe_n[1], 2))
      else $error("staggered rows not one edge apart");
   a_refresh_low: assert property (settled && !access_busy && $fell(row_strobe_n[0]) |->
      ##1 (!row_strobe_n[0] || !settled) ##1 (row_strobe_n[0] || !settled))
      else $error("refresh row low time wrong");
   a_cfg_readback: assert property (psel && penable && !pwrite && paddr == CONFIG_OFFSET |->
      prdata[CONFIG_W-1:0] == cfg_q)
      else $error("config read differs from last load");
   c_single_code: cover property (settled && access_busy && code == 3'h7);
   c_stagger_refresh: cover property (settled && cfg_q[STAGGER_BIT] && !access_busy && row_strobe_n != 4'hF);
   c_pipe_access: cover property (settled && access_busy && cfg_q[PIPE_BIT]);
endmodule
bind vram_strobe_config_decode vram_strobe_sva vram_strobe_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .bank_select_low, .bank_select_high, .column_enable_in, .row_addr,
   .col_addr, .row_strobe_n, .col_strobe_n, .vram_addr, .access_busy);
`default_nettype wire

// ---- tb/vram_model.sv ----
// passive vram array: latches the address at each strobe fall
// assumes strobes and address are registered on pclk
`timescale 1ns/1ps
`default_nettype none
module vram_model
   import vram_strobe_pkg::*;
(
   input wire logic pclk,
   input wire logic [STROBES-1:0] row_strobe_n,
   input wire logic [STROBES-1:0] col_strobe_n,
   input wire logic [VRAM_AW-1:0] vram_addr,
   output logic [VRAM_AW-1:0] row_latched,
   output logic [VRAM_AW-1:0] col_latched,
   output logic [STROBES-1:0] col_hit
);
   logic [STROBES-1:0] row_prev = 4'hF;
   logic [STROBES-1:0] col_prev = 4'hF;
   always @(posedge pclk) begin
      if ((row_prev & ~row_strobe_n) != 4'h0)
         row_latched <= vram_addr;
      if ((col_prev & ~col_strobe_n) != 4'h0) begin
         col_latched <= vram_addr;
         col_hit <= col_prev & ~col_strobe_n;
      end
      row_prev <= row_strobe_n;
      col_prev <= col_strobe_n;
   end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench: apb config, random accesses per code, refresh period per divisor
// assumes the checker binds itself and the vram model only watches the array side
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("mismatch %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module testbench
   import vram_strobe_pkg::*;
;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = 4'h0;
   logic access_req = 1'b0;
   logic bank_select_low = 1'b0;
   logic bank_select_high = 1'b0;
   logic [STROBES-1:0] column_enable_in = '0;
   logic [VRAM_AW-1:0] row_addr = '0;
   logic [VRAM_AW-1:0] col_addr = '0;
   logic [1:0] dl_q = 2'h0;
   wire logic delay_line_clock = dl_q[1];
   wire logic [31:0] prdata;
   wire logic pready, pslverr, access_busy, refresh_busy;
   wire logic [STROBES-1:0] row_strobe_n, col_strobe_n, col_hit;
   wire logic [VRAM_AW-1:0] vram_addr, row_latched, col_latched;
   logic [31:0] rd;
   logic err;
`include "vram_expect.svh"
   vram_strobe_config_decode vram_strobe_config_decode_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb, .prdata, .pready, .pslverr, .delay_line_clock, .access_req, .bank_select_low,
      .bank_select_high, .column_enable_in, .row_addr, .col_addr, .row_strobe_n, .col_strobe_n, .vram_addr,
      .access_busy, .refresh_busy);
   vram_model vram_model_i (.pclk, .row_strobe_n, .col_strobe_n, .vram_addr, .row_latched, .col_latched, .col_hit);
   // ------------------------------------------------
   // clocks, delay line at a quarter of pclk, timeout
   // ------------------------------------------------
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      dl_q <= dl_q + 2'h1;
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         fails++;
         results();
      end
   end
   // four pclk cycles per delay line rising edge
   function automatic int ref_period(input logic [2:0] p, input logic f);
      return (10 - int'(p)) * (f ? 26 : 30) * 4;
   endfunction
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic access(input logic [2:0] c, input logic pipe);
      logic [3:0] en;
      logic h;
      logic l;
      logic [VRAM_AW-1:0] ra;
      logic [VRAM_AW-1:0] ca;
      int n;
      en = 4'($urandom);
      h = 1'($urandom);
      l = 1'($urandom);
      ra = VRAM_AW'($urandom);
      ca = VRAM_AW'($urandom);
      n = 0;
      apb(1'b1, CONFIG_OFFSET, {22'h0, 1'($urandom), pipe, 1'b0, c, 4'h0}, 4'h3);
      bank_select_high <= h;
      bank_select_low <= l;
      column_enable_in <= en;
      row_addr <= ra;
      col_addr <= ca;
      repeat (16) @(posedge pclk);
      access_req <= 1'b1;
      while (access_busy !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      repeat (5) @(posedge pclk);
      `CHK("row strobes", ~row_exp(c, h, l), row_strobe_n)
      `CHK("col strobes", ~(col_exp(c, h, l) & en), col_strobe_n)
      `CHK("vram address", pipe ? ca : ra, vram_addr)
      access_req <= 1'b0;
      while (access_busy !== 1'b0 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      `CHK("released strobes", 8'hFF, {row_strobe_n, col_strobe_n})
      `CHK("row at fall", ra, row_latched)
      if ((col_exp(c, h, l) & en) != 4'h0) begin
         `CHK("col at fall", ca, col_latched)
         `CHK("cols fallen", col_exp(c, h, l) & en, col_hit)
      end
   endtask
   task automatic period(input logic [2:0] p, input logic f);
      int t0;
      apb(1'b1, CONFIG_OFFSET, {22'h0, 1'($urandom), 2'h0, 3'($urandom), f, p}, 4'h3);
      repeat (3) begin
         t0 = cyc;
         while (refresh_busy !== 1'b0) @(posedge pclk);
         while (refresh_busy !== 1'b1) @(posedge pclk);
      end
      `CHK("refresh period", 1'b1, (cyc - t0) inside {[ref_period(p, f) - 1 : ref_period(p, f) + 1]})
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      void'($urandom(38137));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CONFIG_OFFSET, 32'h0, 4'h0);
      `CHK("config reset", 32'h30, rd)
      apb(1'b1, CONFIG_OFFSET, 32'h3FF, 4'h1);
      apb(1'b0, CONFIG_OFFSET, 32'h0, 4'h0);
      `CHK("lane write", 32'hFF, rd)
      apb(1'b1, STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF);
      `CHK("status write", 1'b0, err)
      apb(1'b0, 12'h008, 32'h0, 4'h0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd})
      for (int i = 0; i < 16; i++)
         access(3'(i), i[3]);
      apb(1'b0, CONFIG_OFFSET, 32'h0, 4'h0);
      `CHK("config held", 32'h170, rd & 32'hFFFF_FDFF)
      for (int p = 0; p < 8; p++)
         period(3'(p), p[0]);
      results();
   end
endmodule
`default_nettype wire
